// *** slvi_pkg.sv ***
// shared constants and carrier types for the serial line interrupt control
package slvi_pkg;

  // status register write data positions
  localparam int unsigned RX_IRQ_EN_BIT = 6;
  localparam int unsigned MODEM_IRQ_EN_BIT = 5;
  localparam int unsigned TX_IRQ_EN_BIT = 6;
  localparam int unsigned WR_DATA_W = 8;

  // vector layout: bits 8:3 from jumpers, bit 2 from source, bits 1:0 never driven
  localparam int unsigned VEC_W = 9;
  localparam int unsigned VEC_JUMPER_W = 6;
  localparam int unsigned VEC_SRC_BIT = 2;
  localparam logic [VEC_JUMPER_W-1:0] VEC_JUMPER_DEFAULT = 6'h06;
  localparam logic VEC_DIGIT_RX = 1'h0;
  localparam logic VEC_DIGIT_TX = 1'h1;
  localparam logic [1:0] VEC_LOW_UNDRIVEN = 2'h0;

  // request levels four to seven, one-hot on the level lines
  localparam int unsigned LEVELS = 4;
  localparam logic [1:0] LEVEL_SEL_FOUR = 2'h0;

  typedef struct packed {
    logic [1:0] level_sel;
    logic [VEC_JUMPER_W-1:0] vector_hi;
    logic modem_irq_jumper;
    logic dma_sample_jumper;
  } slvi_cfg_t;

  typedef struct packed {
    logic ring;
    logic carrier;
    logic peer_may_send;
    logic secondary_receive_line;
  } slvi_modem_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REQUEST,
    ST_ACKED,
    ST_MASTER
  } slvi_state_t;

endpackage

// *** slvi_irq_ctrl.sv ***
// interrupt request, bus arbitration and vector logic for the serial line interface
`timescale 1ns/10ps

// Behaviour
// RULE1: vector low octal digit is 0 for receiver, 4 for transmitter, not jumpered.
// RULE2: status write bit 06 sets receive enable; request while enable and char ready.
// RULE3: status write bit 05 sets modem enable; request while enable and modem flag.
// RULE4: modem flag is set by activity on ring, carrier, may-send, secondary lines.
// RULE5: receive-done and modem requests merge into one receiver-side source.
// RULE6: transmit status bit 06 sets transmit enable; request while enable and holding empty.
// RULE7: request goes out on the configured level line, level four by default.
// RULE8: on grant give selection ack, then take bus busy once busy, sync, grant false.
// RULE9: receiver side is served first when both sides are pending.
// RULE10: six jumpers set vector bits 8:3; bits 1:0 are never driven.
// RULE11: data line two low for receiver vector 060, high for transmitter 064.
// RULE12: with nothing pending the incoming grant passes straight to the outgoing grant.
// RULE13: software keeps condition and enable until its routine clears one.
// RULE14: bus mastership is released once the processor has latched the vector.
// RULE15: a served source requests again only after its request level drops and returns.
// RULE16: software rechecks receiver conditions or masks 05 and 06 during the routine.
// RULE17: the logic never raises a direct transfer request.
// RULE18: with sampling enabled, a direct transfer request holds off our request.
// RULE19: a configuration option disables modem interrupts altogether.
// RULE20: reading receiver status or bus initialize clears the modem flag.
// RULE21: receive buffer access pulses a clear of the character ready condition.
// RULE22: bus initialize clears enables, re-arm inhibits and any pending request.
module slvi_irq_ctrl
  import slvi_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic bus_initialize,
  // configuration straps
  input wire slvi_cfg_t cfg,
  // status register access strobes
  input wire logic rx_status_wr,
  input wire logic tx_status_wr,
  input wire logic [WR_DATA_W-1:0] wr_data,
  input wire logic rx_status_rd,
  input wire logic rx_buffer_access,
  // serial core conditions
  input wire logic rx_char_ready,
  input wire logic uart_tx_ready,
  output logic rx_ready_clear,
  // modem lines from the far side
  input wire slvi_modem_t modem_lines,
  // readable status
  output logic rx_irq_enable,
  output logic modem_irq_enable,
  output logic tx_irq_enable,
  output logic modem_change,
  // system bus arbitration
  output logic [LEVELS-1:0] bus_request,
  input wire logic [LEVELS-1:0] grant_chain_in,
  output logic [LEVELS-1:0] grant_chain_out,
  output logic selection_ack,
  input wire logic bus_busy,
  output logic bus_busy_out,
  input wire logic slave_sync,
  input wire logic direct_transfer_request,
  output logic direct_transfer_out,
  // interrupt vector
  output logic irq_strobe,
  output logic [VEC_W-1:0] vector_out,
  output logic vector_oe,
  output logic data_line_two
);

  function automatic logic changed(input logic now_v, input logic was_v);
    changed = now_v ^ was_v;
  endfunction

  // modem lines: two-stage sync, then a third stage for edge detection
  slvi_modem_t meta_q, sync_q, prev_q;
  slvi_modem_t meta_d, sync_d, prev_d;
  logic modem_event;

  always_comb
  begin
    meta_d = modem_lines;
    sync_d = meta_q;
    prev_d = sync_q;
    // ring counts on its rising edge only, the others on either edge
    modem_event = (sync_q.ring & ~prev_q.ring) // [RULE4]
      | changed(sync_q.carrier, prev_q.carrier)
      | changed(sync_q.peer_may_send, prev_q.peer_may_send)
      | changed(sync_q.secondary_receive_line, prev_q.secondary_receive_line);
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  // enables, modem flag and clear pulse
  logic rx_en_q, modem_en_q, tx_en_q, modem_flag_q, rx_clr_q;
  logic rx_en_d, modem_en_d, tx_en_d, modem_flag_d, rx_clr_d;

  always_comb
  begin
    rx_en_d = rx_en_q;
    modem_en_d = modem_en_q;
    tx_en_d = tx_en_q;
    modem_flag_d = modem_flag_q;
    if (rx_status_wr)
    begin
      rx_en_d = wr_data[RX_IRQ_EN_BIT]; // [RULE2]
      modem_en_d = wr_data[MODEM_IRQ_EN_BIT]; // [RULE3]
    end
    if (tx_status_wr)
      tx_en_d = wr_data[TX_IRQ_EN_BIT]; // [RULE6]
    if (rx_status_rd)
      modem_flag_d = 1'h0; // [RULE20]
    // an edge in the read cycle must not be lost, so the set comes last
    if (modem_event)
      modem_flag_d = 1'h1; // [RULE4]
    rx_clr_d = rx_buffer_access; // [RULE21]
    if (bus_initialize)
    begin
      rx_en_d = 1'h0; // [RULE22]
      modem_en_d = 1'h0;
      tx_en_d = 1'h0;
      modem_flag_d = 1'h0; // [RULE20]
      rx_clr_d = 1'h0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_en_q <= 1'h0;
      modem_en_q <= 1'h0;
      tx_en_q <= 1'h0;
      modem_flag_q <= 1'h0;
      rx_clr_q <= 1'h0;
    end
    else
    begin
      rx_en_q <= rx_en_d;
      modem_en_q <= modem_en_d;
      tx_en_q <= tx_en_d;
      modem_flag_q <= modem_flag_d;
      rx_clr_q <= rx_clr_d;
    end
  end

  assign rx_irq_enable = rx_en_q;
  assign modem_irq_enable = modem_en_q;
  assign tx_irq_enable = tx_en_q;
  assign modem_change = modem_flag_q;
  assign rx_ready_clear = rx_clr_q;

  // request sources
  logic rx_side_request, tx_side_request;
  assign rx_side_request = (rx_en_q & rx_char_ready) // [RULE2] [RULE5]
    | (modem_en_q & modem_flag_q & cfg.modem_irq_jumper); // [RULE3] [RULE19]
  assign tx_side_request = tx_en_q & uart_tx_ready; // [RULE6]

  // arbitration sequencer with per-source re-arm inhibit
  slvi_state_t state_q, state_d;
  logic rx_inh_q, tx_inh_q, src_tx_q, vec_oe_q, strobe_q;
  logic rx_inh_d, tx_inh_d, src_tx_d, vec_oe_d, strobe_d;
  logic [VEC_W-1:0] vec_q, vec_d;
  logic rx_live, tx_live, hold_off, my_grant;

  assign rx_live = rx_side_request & ~rx_inh_q;
  assign tx_live = tx_side_request & ~tx_inh_q;
  assign hold_off = cfg.dma_sample_jumper & direct_transfer_request; // [RULE18]
  assign my_grant = grant_chain_in[cfg.level_sel];

  always_comb
  begin
    state_d = state_q;
    src_tx_d = src_tx_q;
    vec_d = vec_q;
    vec_oe_d = vec_oe_q;
    strobe_d = strobe_q;
    rx_inh_d = rx_inh_q;
    tx_inh_d = tx_inh_q;
    // inhibit lifts only once the source's level has dropped
    if (!rx_side_request)
      rx_inh_d = 1'h0; // [RULE15]
    if (!tx_side_request)
      tx_inh_d = 1'h0; // [RULE15]
    case (state_q)
      ST_IDLE:
      begin
        if ((rx_live | tx_live) & ~hold_off)
          state_d = ST_REQUEST; // [RULE18]
      end
      ST_REQUEST:
      begin
        if (!(rx_live | tx_live))
          state_d = ST_IDLE; // [RULE13]
        else if (my_grant)
        begin
          src_tx_d = ~rx_live; // [RULE9]
          state_d = ST_ACKED; // [RULE8]
        end
      end
      ST_ACKED:
      begin
        if (!bus_busy && !slave_sync && !my_grant)
        begin
          state_d = ST_MASTER; // [RULE8]
          vec_oe_d = 1'h1;
          strobe_d = 1'h1;
          vec_d = {cfg.vector_hi, (src_tx_q ? VEC_DIGIT_TX : VEC_DIGIT_RX), VEC_LOW_UNDRIVEN}; // [RULE1] [RULE10] [RULE11]
        end
      end
      ST_MASTER:
      begin
        if (slave_sync)
        begin
          // processor has latched the vector: let go of everything
          state_d = ST_IDLE; // [RULE14]
          vec_oe_d = 1'h0;
          strobe_d = 1'h0;
          if (src_tx_q)
            tx_inh_d = 1'h1; // [RULE15]
          else
            rx_inh_d = 1'h1; // [RULE15]
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
    if (bus_initialize)
    begin
      state_d = ST_IDLE; // [RULE22]
      rx_inh_d = 1'h0;
      tx_inh_d = 1'h0;
      vec_oe_d = 1'h0;
      strobe_d = 1'h0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= ST_IDLE;
      src_tx_q <= 1'h0;
      vec_q <= '0;
      vec_oe_q <= 1'h0;
      strobe_q <= 1'h0;
      rx_inh_q <= 1'h0;
      tx_inh_q <= 1'h0;
    end
    else
    begin
      state_q <= state_d;
      src_tx_q <= src_tx_d;
      vec_q <= vec_d;
      vec_oe_q <= vec_oe_d;
      strobe_q <= strobe_d;
      rx_inh_q <= rx_inh_d;
      tx_inh_q <= tx_inh_d;
    end
  end

  // handshake outputs
  logic requesting;
  assign requesting = (state_q == ST_REQUEST);

  always_comb
  begin
    bus_request = '0;
    grant_chain_out = grant_chain_in; // [RULE12]
    if (requesting)
      bus_request[cfg.level_sel] = 1'h1; // [RULE7]
    // once we want the bus our own grant stops here
    if (state_q != ST_IDLE)
      grant_chain_out[cfg.level_sel] = 1'h0;
  end

  assign selection_ack = (state_q == ST_ACKED); // [RULE8]
  assign bus_busy_out = (state_q == ST_MASTER); // [RULE8]
  assign direct_transfer_out = 1'h0; // [RULE17]
  assign irq_strobe = strobe_q;
  assign vector_out = vec_q;
  assign vector_oe = vec_oe_q;
  assign data_line_two = vec_q[VEC_SRC_BIT]; // [RULE11]

endmodule // slvi_irq_ctrl

// *** slvi_irq_ctrl_properties.sv ***
// port assertions for the serial line interrupt control
`timescale 1ns/10ps
module slvi_irq_ctrl_properties
  import slvi_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic bus_initialize,
  // configuration and strobes
  input wire slvi_cfg_t cfg,
  input wire logic rx_status_wr,
  input wire logic tx_status_wr,
  input wire logic [WR_DATA_W-1:0] wr_data,
  input wire logic rx_buffer_access,
  // status
  input wire logic rx_ready_clear,
  input wire logic rx_irq_enable,
  input wire logic modem_irq_enable,
  input wire logic tx_irq_enable,
  input wire logic modem_change,
  // bus
  input wire logic [LEVELS-1:0] bus_request,
  input wire logic [LEVELS-1:0] grant_chain_in,
  input wire logic [LEVELS-1:0] grant_chain_out,
  input wire logic selection_ack,
  input wire logic bus_busy,
  input wire logic bus_busy_out,
  input wire logic slave_sync,
  input wire logic direct_transfer_request,
  input wire logic direct_transfer_out,
  input wire logic [VEC_W-1:0] vector_out,
  input wire logic vector_oe,
  input wire logic data_line_two
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_vec_jumper_bits: assert property (vector_oe |-> vector_out[1:0] == VEC_LOW_UNDRIVEN && vector_out[8:3] == cfg.vector_hi)
    else $error("vector jumper bits wrong");
  a_line_two_src: assert property (vector_oe |-> data_line_two == vector_out[VEC_SRC_BIT])
    else $error("data line two differs from vector");
  a_rx_enable_wr: assert property (rx_status_wr && !bus_initialize |=> rx_irq_enable == $past(wr_data[RX_IRQ_EN_BIT]) && modem_irq_enable == $past(wr_data[MODEM_IRQ_EN_BIT]))
    else $error("receiver enables not loaded");
  a_tx_enable_wr: assert property (tx_status_wr && !bus_initialize |=> tx_irq_enable == $past(wr_data[TX_IRQ_EN_BIT]))
    else $error("transmit enable not loaded");
  a_req_level: assert property (bus_request != '0 |-> bus_request == (4'h1 << cfg.level_sel))
    else $error("request on wrong level");
  a_grant_pass: assert property (bus_request == '0 && !selection_ack && !bus_busy_out |-> grant_chain_out == grant_chain_in)
    else $error("grant not passed through");
  a_grant_ack: assert property (bus_request != '0 && grant_chain_in[cfg.level_sel] |=> selection_ack && bus_request == '0)
    else $error("grant not acknowledged");
  a_master_entry: assert property (selection_ack && !bus_busy && !slave_sync && !grant_chain_in[cfg.level_sel] |=> bus_busy_out && vector_oe)
    else $error("bus busy not taken");
  a_master_release: assert property (bus_busy_out && slave_sync |=> !bus_busy_out && !vector_oe && !selection_ack)
    else $error("bus not released");
  a_no_direct: assert property (direct_transfer_out == 1'b0)
    else $error("direct transfer request raised");
  a_hold_off: assert property (cfg.dma_sample_jumper && direct_transfer_request && bus_request == '0 |=> bus_request == '0)
    else $error("request despite direct transfer");
  a_init_clear: assert property (bus_initialize |=> !rx_irq_enable && !modem_irq_enable && !tx_irq_enable && !modem_change && bus_request == '0)
    else $error("initialize left state set");
  a_ready_clear: assert property (rx_buffer_access |=> rx_ready_clear)
    else $error("ready clear pulse missing");
endmodule // slvi_irq_ctrl_properties

bind slvi_irq_ctrl slvi_irq_ctrl_properties slvi_irq_ctrl_properties_inst (.mclk, .rst_b, .bus_initialize, .cfg,
  .rx_status_wr, .tx_status_wr, .wr_data, .rx_buffer_access, .rx_ready_clear, .rx_irq_enable, .modem_irq_enable,
  .tx_irq_enable, .modem_change, .bus_request, .grant_chain_in, .grant_chain_out, .selection_ack, .bus_busy,
  .bus_busy_out, .slave_sync, .direct_transfer_request, .direct_transfer_out, .vector_out, .vector_oe, .data_line_two);

// *** slvi_cpu_arbiter.sv ***
// processor-side arbiter model: grants the request level, syncs once the vector is up
`timescale 1ns/10ps
module slvi_cpu_arbiter
  import slvi_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // device side
  input wire logic [LEVELS-1:0] bus_request,
  input wire logic selection_ack,
  input wire logic bus_busy_out,
  input wire logic vector_oe,
  // grant pacing, zero answers promptly
  input wire logic [3:0] grant_delay,
  // answers
  output logic [LEVELS-1:0] grant_chain_in,
  output logic slave_sync
);
  logic [3:0] wait_q;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      grant_chain_in <= '0;
      slave_sync <= 1'b0;
      wait_q <= 4'h0;
    end
    else
    begin
      // grant held until acknowledged, then withdrawn so mastership can be taken
      grant_chain_in <= (wait_q == 4'h0 && !selection_ack) ? bus_request : '0;
      wait_q <= (bus_request == '0) ? grant_delay : ((wait_q != 4'h0) ? wait_q - 4'h1 : wait_q);
      // one-cycle sync marks the vector as latched
      slave_sync <= bus_busy_out && vector_oe && !slave_sync;
    end
  end
endmodule // slvi_cpu_arbiter

// *** slvi_irq_ctrl_tb.sv ***
// self-checking bench for the serial line interrupt control
`timescale 1ns/10ps
module slvi_irq_ctrl_tb
  import slvi_pkg::*;
();
  logic mclk, rst_b, bus_initialize, rx_status_wr, tx_status_wr, rx_status_rd, rx_buffer_access;
  logic rx_char_ready, uart_tx_ready, rx_ready_clear, rx_irq_enable, modem_irq_enable, tx_irq_enable, modem_change;
  logic selection_ack, bus_busy, bus_busy_out, slave_sync, direct_transfer_request, direct_transfer_out;
  logic irq_strobe, vector_oe, data_line_two;
  logic [WR_DATA_W-1:0] wr_data;
  logic [LEVELS-1:0] bus_request, grant_chain_in, grant_chain_out;
  logic [VEC_W-1:0] vector_out;
  logic [3:0] grant_delay;
  slvi_cfg_t cfg;
  slvi_modem_t modem_lines;
  int failures, n_compared, i;

  slvi_irq_ctrl slvi_irq_ctrl_inst (.mclk, .rst_b, .bus_initialize, .cfg, .rx_status_wr, .tx_status_wr, .wr_data,
    .rx_status_rd, .rx_buffer_access, .rx_char_ready, .uart_tx_ready, .rx_ready_clear, .modem_lines, .rx_irq_enable,
    .modem_irq_enable, .tx_irq_enable, .modem_change, .bus_request, .grant_chain_in, .grant_chain_out, .selection_ack,
    .bus_busy, .bus_busy_out, .slave_sync, .direct_transfer_request, .direct_transfer_out, .irq_strobe, .vector_out,
    .vector_oe, .data_line_two);
  slvi_cpu_arbiter slvi_cpu_arbiter_inst (.mclk, .rst_b, .bus_request, .selection_ack, .bus_busy_out, .vector_oe,
    .grant_delay, .grant_chain_in, .slave_sync);

  task chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task give_verdict;
    $display("compared %0d mismatched %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // status write: one strobe cycle, released at the next edge
  task wr(input logic tx, input logic [7:0] d);
    @(posedge mclk);
    rx_status_wr <= !tx;
    tx_status_wr <= tx;
    wr_data <= d;
    @(posedge mclk);
    rx_status_wr <= 1'b0;
    tx_status_wr <= 1'b0;
  endtask

  // waits for the arbiter's sync, while the vector is still on the lines
  task serve(input logic [8:0] exp);
    for (int k = 0; k < 60; k++)
    begin
      @(posedge mclk);
      #1;
      if (slave_sync === 1'b1)
        break;
    end
    // a missed sync would leave the previous vector standing, so the handshake is checked too
    chk("vector handshake", {6'h00, irq_strobe, vector_oe, slave_sync}, 9'h007);
    chk("vector", vector_out, exp);
    chk("line two", {8'h00, data_line_two}, {8'h00, exp[2]});
  endtask

  task settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  initial
  begin
    repeat (5000) @(posedge mclk);
    failures++;
    give_verdict();
  end

  initial
  begin
    {rst_b, bus_initialize, rx_status_wr, tx_status_wr, rx_status_rd, rx_buffer_access} = '0;
    {rx_char_ready, uart_tx_ready, bus_busy, direct_transfer_request, wr_data, grant_delay} = '0;
    failures = 0;
    n_compared = 0;
    modem_lines = '0;
    cfg = '0;
    cfg.vector_hi = VEC_JUMPER_DEFAULT;
    cfg.modem_irq_jumper = 1'b1;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    wr(1'b0, 8'h40);
    rx_char_ready <= 1'b1;
    settle(2);
    chk("request", {5'h00, bus_request}, 9'h001);
    serve(9'h030);
    settle(6);
    chk("inhibit", {5'h00, bus_request}, 9'h000);
    @(posedge mclk) rx_buffer_access <= 1'b1;
    @(posedge mclk) rx_buffer_access <= 1'b0;
    #1;
    chk("ready clear", {8'h00, rx_ready_clear}, 9'h001);
    @(posedge mclk) rx_char_ready <= 1'b0;
    @(posedge mclk) rx_char_ready <= 1'b1;
    serve(9'h030);
    $display("test 1 done");
    grant_delay <= 4'h8;
    wr(1'b0, 8'h00);
    uart_tx_ready <= 1'b1;
    wr(1'b1, 8'h40);
    wr(1'b0, 8'h40);
    serve(9'h030);
    serve(9'h034);
    uart_tx_ready <= 1'b0;
    rx_char_ready <= 1'b0;
    wr(1'b0, 8'h00);
    $display("test 2 done");
    for (i = 0; i < 4; i++)
    begin
      @(posedge mclk) modem_lines <= modem_lines | (4'h8 >> i);
      settle(6);
      chk("modem flag set", {8'h00, modem_change}, 9'h001);
      @(posedge mclk) rx_status_rd <= 1'b1;
      @(posedge mclk) rx_status_rd <= 1'b0;
      #1;
      chk("modem flag read", {8'h00, modem_change}, 9'h000);
    end
    wr(1'b0, 8'h20);
    @(posedge mclk) modem_lines <= '0;
    serve(9'h030);
    @(posedge mclk) rx_status_rd <= 1'b1;
    cfg.modem_irq_jumper <= 1'b0;
    @(posedge mclk) rx_status_rd <= 1'b0;
    @(posedge mclk) modem_lines <= 4'h4;
    settle(8);
    chk("modem off", {5'h00, bus_request}, 9'h000);
    $display("test 3 done");
    cfg <= '{level_sel: 2'h2, vector_hi: 6'h2a, modem_irq_jumper: 1'b1, dma_sample_jumper: 1'b1};
    direct_transfer_request <= 1'b1;
    uart_tx_ready <= 1'b1;
    wr(1'b1, 8'h40);
    settle(6);
    chk("hold off", {5'h00, bus_request}, 9'h000);
    @(posedge mclk) direct_transfer_request <= 1'b0;
    settle(3);
    chk("level six", {5'h00, bus_request}, 9'h004);
    // modem flag is still set from test 3, so the receiver side goes first
    serve(9'h150);
    serve(9'h154);
    $display("test 4 done");
    wr(1'b0, 8'h60);
    @(posedge mclk) bus_initialize <= 1'b1;
    @(posedge mclk) bus_initialize <= 1'b0;
    #1;
    chk("init enables", {6'h00, rx_irq_enable, modem_irq_enable, tx_irq_enable}, 9'h000);
    wr(1'b1, 8'h40);
    bus_busy <= 1'b1;
    settle(24);
    chk("busy wait", {7'h00, selection_ack, bus_busy_out}, 9'h002);
    bus_busy <= 1'b0;
    serve(9'h154);
    $display("test 5 done");
    give_verdict();
  end
endmodule // slvi_irq_ctrl_tb
